// ==== rtl/rcl_reset_ctrl.sv ====
/*
 * Reset sequencer, reset-cause register, watchdog service detector,
 * low-voltage monitor control and stop-mode gating, behind an APB slave.
 * Assumes SRST is the power-on reset; comparator and pin inputs are
 * asynchronous; CPU event inputs are one-cycle pulses on CLOCK.
 */
`timescale 1ns/10ps

// Function
// - Low-voltage monitor runs only while detect enable is set or a supply-checked reset hold is on.
// - Entering stop switches the monitor off unless stop enable is set.
// - Detect and stop enable both set refuse the deepest stop mode.
// - After power-on, reset holds until supply above the low threshold.
// - Power-on sets both power-on and low-voltage cause flags.
// - Reset enable plus a detected low voltage raises a system reset.
// - Threshold select bit chooses the detection trip threshold.
// - After low-voltage reset, hold until supply above chosen threshold.
// - Low-voltage flag is set after low-voltage or power-on reset.
// - Warning with its interrupt enabled sets warn flag and requests irq.
// - Read-only cause flags show the source of the latest reset.
// - Debug-forced reset leaves every cause flag cleared.
// - Enabled watchdog resets on cause writes other than 55h or AAh.
// - Writing 55h then AAh clears the watchdog, flags untouched.
// - Other resets set active pin, watchdog, opcode, address flags only.
// - Cause layout bits 7,6,5,4,3,1; bits 2 and 0 read zero.
// - No watchdog timeout reset while watchdog enable is zero.
// - Bad opcode, disabled stop or disabled debug entry reset the chip.
module rcl_reset_ctrl #(
    parameter int WDOG_TIMEOUT = rcl_pkg::WDOG_TIMEOUT_DEFAULT
) (
    input  wire logic        CLOCK,
    input  wire logic        SRST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        PIN_RESET_N,
    input  wire logic        LV_BELOW_LOW,
    input  wire logic        LV_BELOW_HIGH,
    input  wire logic        LV_WARN_LEVEL,
    input  wire logic        BAD_OPCODE,
    input  wire logic        BAD_ADDRESS,
    input  wire logic        STOP_REQ,
    input  wire logic        STOP_DEEP,
    input  wire logic        DEBUG_ENTER_REQ,
    input  wire logic        WAKE,
    output logic             SYS_RESET,
    output logic             LV_MONITOR_ON,
    output logic             STOP_ACTIVE,
    output logic             STOP2_ACTIVE,
    output logic             LOWVOLT_WARN_IRQ,
    output logic             IRQ
);
    localparam int WDOG_W = $clog2(WDOG_TIMEOUT);
    localparam int HOLD_W = $clog2(rcl_pkg::RST_HOLD_CYCLES + 1);
    localparam logic [WDOG_W-1:0] WDOG_LAST = WDOG_W'(WDOG_TIMEOUT - 1);
    localparam logic [HOLD_W-1:0] HOLD_LAST =
        HOLD_W'(rcl_pkg::RST_HOLD_CYCLES - 1);

    // Counter width must fit the timeout and stay practical
    if (WDOG_TIMEOUT < 4 || WDOG_TIMEOUT > (1 << 24)) begin : g_chk
        $error("WDOG_TIMEOUT out of range");
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);

    rcl_pkg::rcl_state_type state;
    rcl_pkg::rcl_svc_type   svc;
    rcl_pkg::rcl_cause_type cause;
    rcl_pkg::rcl_cause_type next_cause;
    logic [3:0]        sync1;
    logic [3:0]        sync2;
    logic [HOLD_W-1:0] hold_cnt;
    logic              hold_supply;
    logic              hold_high;
    logic [WDOG_W-1:0] wdog_cnt;
    logic              detect_en;
    logic              stop_en;
    logic              reset_en;
    logic              warn_ie;
    logic              thresh_sel;
    logic              warn_flag;
    logic              wdog_en;
    logic              stop_instr_en;
    logic              dbg_mode_en;
    logic              in_stop;
    logic              in_deep;
    logic [1:0]        irq_stat;
    logic [1:0]        irq_mask;

    // Two-flop synchronisers; only sync2 is read by logic
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            sync1 <= 4'h1;
            sync2 <= 4'h1;
        end else begin
            sync1 <= {LV_WARN_LEVEL, LV_BELOW_HIGH, LV_BELOW_LOW,
                      PIN_RESET_N};
            sync2 <= sync1;
        end
    end

    wire pin_active = ~sync2[0];
    wire below_low  = sync2[1];
    wire below_high = sync2[2];
    wire warn_level = sync2[3];
    wire run        = (state == rcl_pkg::RCL_RUN);

    // APB decode; zero wait states, error on unmapped address
    wire apb_setup = PSEL & ~PENABLE;
    wire apb_wr    = PSEL & PENABLE & PWRITE;
    wire hit_cause = (PADDR == rcl_pkg::ADDR_CAUSE);
    wire hit_dbg   = (PADDR == rcl_pkg::ADDR_DBG);
    wire hit_pmc1  = (PADDR == rcl_pkg::ADDR_PMC1);
    wire hit_pmc2  = (PADDR == rcl_pkg::ADDR_PMC2);
    wire hit_sopt  = (PADDR == rcl_pkg::ADDR_SOPT);
    wire hit_istat = (PADDR == rcl_pkg::ADDR_IRQ_STAT);
    wire hit_imask = (PADDR == rcl_pkg::ADDR_IRQ_MASK);
    wire mapped    = hit_cause | hit_dbg | hit_pmc1 | hit_pmc2 |
                     hit_sopt | hit_istat | hit_imask;
    wire [7:0] wd8 = PWDATA[7:0];
    // Writes are ignored while the system is held in reset
    wire wr_ok     = apb_wr & run;

    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~mapped;

    // Watchdog service detector
    wire wr_cause  = wr_ok & hit_cause;
    wire key_arm   = (wd8 == rcl_pkg::WDOG_KEY_ARM);
    wire key_done  = (wd8 == rcl_pkg::WDOG_KEY_DONE);
    wire svc_bad   = wr_cause & ~key_arm & ~key_done;
    wire svc_done  = wr_cause & key_done &
                     (svc == rcl_pkg::RCL_SVC_ARMED);

    // Monitor power: off in stop unless stop enable keeps it alive
    wire monitor_on = detect_en & ~(in_stop & ~stop_en);
    wire below_sel  = thresh_sel ? below_high : below_low;

    // Reset sources, only sampled while running
    wire lv_req    = run & reset_en & monitor_on & below_sel;
    wire wdog_tout = run & wdog_en & ~in_stop &
                     (wdog_cnt == WDOG_LAST);
    wire wdog_req  = run & wdog_en & (svc_bad | wdog_tout);
    wire bad_opcode_flag_req  = run & (BAD_OPCODE |
                     (STOP_REQ & ~stop_instr_en) |
                     (DEBUG_ENTER_REQ & ~dbg_mode_en));
    wire bad_address_flag_req  = run & BAD_ADDRESS;
    wire pin_req   = run & pin_active;
    wire dbg_req   = wr_ok & hit_dbg & wd8[rcl_pkg::DBG_FORCE_BIT];
    wire any_req   = lv_req | wdog_req | bad_opcode_flag_req | bad_address_flag_req |
                     pin_req | dbg_req;

    // Stop entry; deep stop refused while the monitor must stay up
    wire stop_go   = run & STOP_REQ & stop_instr_en & ~in_stop & ~any_req;
    wire deep_ok   = STOP_DEEP & ~(detect_en & stop_en);
    wire warn_set  = run & monitor_on & warn_ie & warn_level;

    // Cause captured at reset entry; a debug force adds no source
    always_comb begin
        next_cause = cause;
        if (lv_req) begin
            next_cause         = '0;
            next_cause.por     = cause.por;
            next_cause.lowvolt = 1'b1;
        end else if (any_req) begin
            next_cause             = '0;
            next_cause.pin         = pin_req;
            next_cause.wdog        = wdog_req;
            next_cause.bad_opcode  = bad_opcode_flag_req;
            next_cause.bad_address = bad_address_flag_req;
        end
    end

    // Supply needed to leave the hold, by threshold chosen at entry
    wire hold_low_v = hold_supply &
                      (hold_high ? below_high : below_low);
    wire hold_done  = (hold_cnt == HOLD_LAST) & ~pin_active & ~hold_low_v;

    // Reset sequencer
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            state       <= rcl_pkg::RCL_HOLD;
            hold_cnt    <= '0;
            hold_supply <= 1'b1;
            hold_high   <= 1'b0;
            cause       <= rcl_pkg::rcl_cause_type'({
                rcl_pkg::CAUSE_POR_VALUE[7:3],
                rcl_pkg::CAUSE_POR_VALUE[1]});
        end else if (run) begin
            if (any_req) begin
                state       <= rcl_pkg::RCL_HOLD;
                hold_cnt    <= '0;
                hold_supply <= lv_req;
                hold_high   <= thresh_sel;
                cause       <= next_cause;
            end
        end else begin
            if (hold_cnt != HOLD_LAST) begin
                hold_cnt <= hold_cnt + 1'b1;
            end
            if (hold_done) begin
                state <= rcl_pkg::RCL_RUN;
            end
        end
    end

    // Power control: kept across all but power-on reset
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            {warn_ie, reset_en, stop_en, detect_en} <=
                rcl_pkg::PMC1_RESET[5:2];
            thresh_sel <= rcl_pkg::PMC2_RESET[rcl_pkg::PMC2_THR_BIT];
        end else if (wr_ok & hit_pmc1) begin
            {warn_ie, reset_en, stop_en, detect_en} <= wd8[5:2];
        end else if (wr_ok & hit_pmc2) begin
            thresh_sel <= wd8[rcl_pkg::PMC2_THR_BIT];
        end
    end

    // Warn flag: set wins over the acknowledge write
    always_ff @(posedge CLOCK) begin
        if (SRST | ~run) begin
            warn_flag <= 1'b0;
        end else if (warn_set) begin
            warn_flag <= 1'b1;
        end else if (wr_ok & hit_pmc1 & wd8[rcl_pkg::PMC1_WACK_BIT]) begin
            warn_flag <= 1'b0;
        end
    end

    // System options, returned to defaults by every reset
    always_ff @(posedge CLOCK) begin
        if (SRST | ~run) begin
            wdog_en       <= rcl_pkg::SOPT_RESET[rcl_pkg::SOPT_WDOG_BIT];
            stop_instr_en <= rcl_pkg::SOPT_RESET[rcl_pkg::SOPT_STOP_BIT];
            dbg_mode_en   <= rcl_pkg::SOPT_RESET[rcl_pkg::SOPT_DBGM_BIT];
        end else if (wr_ok & hit_sopt) begin
            wdog_en       <= wd8[rcl_pkg::SOPT_WDOG_BIT];
            stop_instr_en <= wd8[rcl_pkg::SOPT_STOP_BIT];
            dbg_mode_en   <= wd8[rcl_pkg::SOPT_DBGM_BIT];
        end
    end

    // Watchdog counter and service sequence
    always_ff @(posedge CLOCK) begin
        if (SRST | ~run | svc_done | ~wdog_en) begin
            wdog_cnt <= '0;
        end else if (~in_stop) begin
            wdog_cnt <= wdog_cnt + 1'b1;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST | ~run) begin
            svc <= rcl_pkg::RCL_SVC_IDLE;
        end else if (wr_cause) begin
            svc <= key_arm ? rcl_pkg::RCL_SVC_ARMED
                           : rcl_pkg::RCL_SVC_IDLE;
        end
    end

    // Stop state; WAKE or any reset leaves it
    always_ff @(posedge CLOCK) begin
        if (SRST | ~run | WAKE) begin
            in_stop <= 1'b0;
            in_deep <= 1'b0;
        end else if (stop_go) begin
            in_stop <= 1'b1;
            in_deep <= deep_ok;
        end
    end

    // Interrupt status: set wins over write-one-to-clear
    wire [1:0] irq_set = {svc_done, warn_set};
    wire [1:0] irq_clr = (wr_ok & hit_istat) ? wd8[1:0] : 2'h0;

    always_ff @(posedge CLOCK) begin
        if (SRST | ~run) begin
            irq_stat <= 2'h0;
            irq_mask <= rcl_pkg::IRQ_MASK_RESET;
        end else begin
            irq_stat <= irq_set | (irq_stat & ~irq_clr);
            if (wr_ok & hit_imask) begin
                irq_mask <= wd8[1:0];
            end
        end
    end

    // Read mux; reserved bits read zero
    wire [7:0] cause_rd = {cause.por, cause.pin, cause.wdog,
                           cause.bad_opcode, cause.bad_address, 1'b0,
                           cause.lowvolt, 1'b0};
    wire [7:0] pmc1_rd  = {warn_flag, 1'b0, warn_ie, reset_en, stop_en,
                           detect_en, 2'b00};
    wire [7:0] pmc2_rd  = {2'b00, thresh_sel, 5'h00};
    wire [7:0] sopt_rd  = {wdog_en, 1'b0, stop_instr_en, 4'h0, dbg_mode_en};
    wire [7:0] rd8 = hit_cause ? cause_rd :
                     hit_pmc1  ? pmc1_rd  :
                     hit_pmc2  ? pmc2_rd  :
                     hit_sopt  ? sopt_rd  :
                     hit_istat ? {6'h00, irq_stat} :
                     hit_imask ? {6'h00, irq_mask} : 8'h00;

    // Read data registered in the setup phase, held through access
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            PRDATA <= 32'h0;
        end else if (apb_setup) begin
            PRDATA <= {24'h0, rd8};
        end
    end

    // Outputs
    assign SYS_RESET        = ~run;
    assign LV_MONITOR_ON    = monitor_on | (~run & hold_supply);
    assign STOP_ACTIVE      = in_stop;
    assign STOP2_ACTIVE     = in_stop & in_deep;
    assign LOWVOLT_WARN_IRQ = warn_flag & warn_ie;
    assign IRQ              = |(irq_stat & irq_mask);

    // Checks
    AST_MON_OFF: assert property (~detect_en & run |-> ~LV_MONITOR_ON)
        else $error("monitor on while detect disabled");
    AST_STOP_MON: assert property (in_stop & ~stop_en |-> ~monitor_on)
        else $error("monitor alive in stop");
    AST_NO_DEEP: assert property (STOP2_ACTIVE |-> ~(detect_en & stop_en))
        else $error("deep stop entered with monitor kept");
    AST_HOLD_SUP: assert property (~run & hold_low_v |=> SYS_RESET)
        else $error("released while supply low");
    AST_POR_FLAGS: assert property ($fell(SRST) |->
        cause_rd == rcl_pkg::CAUSE_POR_VALUE)
        else $error("power-on cause wrong");
    AST_LV_RESET: assert property (lv_req |=> SYS_RESET & cause.lowvolt)
        else $error("low-voltage reset missing");
    AST_WARN: assert property (warn_set |=> warn_flag & LOWVOLT_WARN_IRQ)
        else $error("warn flag not set");
    AST_DBG_CLEAR: assert property (dbg_req & ~lv_req & ~pin_req & ~bad_opcode_flag_req
        & ~bad_address_flag_req & ~wdog_req |=> cause_rd == 8'h00)
        else $error("debug reset left a flag");
    AST_BAD_KEY: assert property (svc_bad & wdog_en |=> SYS_RESET
        ##0 (cause.wdog | cause.lowvolt))
        else $error("bad key did not reset");
    AST_SERVICE: assert property (svc_done |=> wdog_cnt == '0
        ##0 $stable(cause_rd) ##0 run)
        else $error("service failed");
    AST_NO_WDOG: assert property (~wdog_en & run |=> $stable(cause)
        or SYS_RESET)
        else $error("watchdog reset while disabled");
    AST_BAD_OPCODE_FLAG: assert property (run & STOP_REQ & ~stop_instr_en & ~lv_req
        |=> SYS_RESET & cause.bad_opcode)
        else $error("disabled stop not trapped");
    AST_HOLD_MIN: assert property ($rose(SYS_RESET) |-> SYS_RESET[*4])
        else $error("reset hold too short");

    // Pin cause, service status and monitor kept alive in stop
    AST_PIN: assert property (pin_req & ~lv_req |=> cause.pin)
        else $error("pin reset cause missing");
    AST_SVC_IRQ: assert property (svc_done |=>
        irq_stat[rcl_pkg::IRQ_SVC_BIT])
        else $error("service status not raised");
    AST_STOP_KEEP: assert property (in_stop & stop_en & detect_en
        |-> LV_MONITOR_ON)
        else $error("monitor dropped in stop");
    COV_PIN_RESET: cover property (pin_req);

    COV_SERVICE: cover property (svc_done);
    COV_LV_RESET: cover property (lv_req ##[1:100] run);
    COV_DEEP_STOP: cover property (STOP2_ACTIVE);
    COV_WARN_IRQ: cover property (IRQ & irq_stat[rcl_pkg::IRQ_WARN_BIT]);

endmodule : rcl_reset_ctrl

// ==== rtl/rcl_pkg.sv ====
/*
 * Constants, register map and carrier types of the reset-cause and
 * low-voltage control block.
 * Assumes a 40 MHz bus clock and a 32-bit APB with 8-bit addresses.
 */
package rcl_pkg;

    // Bus geometry
    localparam int APB_ADDR_W = 8;

    // Register byte addresses
    localparam logic [7:0] ADDR_CAUSE    = 8'h00;
    localparam logic [7:0] ADDR_DBG      = 8'h04;
    localparam logic [7:0] ADDR_PMC1     = 8'h08;
    localparam logic [7:0] ADDR_PMC2     = 8'h0C;
    localparam logic [7:0] ADDR_SOPT     = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

    // system_reset_cause fields
    localparam int CAUSE_POR_BIT  = 7;
    localparam int CAUSE_PIN_BIT  = 6;
    localparam int CAUSE_WDOG_BIT = 5;
    localparam int CAUSE_BAD_OPCODE_FLAG_BIT = 4;
    localparam int CAUSE_BAD_ADDRESS_FLAG_BIT = 3;
    localparam int CAUSE_LV_BIT   = 1;
    localparam logic [7:0] CAUSE_POR_VALUE = 8'h82;

    // debug_force_reset_reg and power_mgmt_ctrl1 / ctrl2 fields
    localparam int DBG_FORCE_BIT  = 0;
    localparam int PMC1_WFLAG_BIT = 7;
    localparam int PMC1_WACK_BIT  = 6;
    localparam int PMC1_WIE_BIT   = 5;
    localparam int PMC1_RSTE_BIT  = 4;
    localparam int PMC1_STPE_BIT  = 3;
    localparam int PMC1_DETE_BIT  = 2;
    localparam int PMC2_THR_BIT   = 5;
    localparam logic [7:0] PMC1_RESET = 8'h14;
    localparam logic [7:0] PMC2_RESET = 8'h00;

    // System option fields
    localparam int SOPT_WDOG_BIT = 7;
    localparam int SOPT_STOP_BIT = 5;
    localparam int SOPT_DBGM_BIT = 0;
    localparam logic [7:0] SOPT_RESET = 8'h80;

    // Interrupt status / mask fields
    localparam int IRQ_WARN_BIT = 0;
    localparam int IRQ_SVC_BIT  = 1;
    localparam int IRQ_W        = 2;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

    // Watchdog service keys
    localparam logic [7:0] WDOG_KEY_ARM  = 8'h55;
    localparam logic [7:0] WDOG_KEY_DONE = 8'hAA;

    // Timing
    localparam int CLK_PERIOD_NS   = 25;
    localparam int RST_HOLD_NS     = 100;
    localparam int RST_HOLD_CYCLES =
        (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WDOG_TIMEOUT_DEFAULT = 262144;

    // Sequencer and service states, Gray along the usual path
    typedef enum logic [1:0] {
        RCL_HOLD = 2'b00,
        RCL_RUN  = 2'b01
    } rcl_state_type;

    typedef enum logic {
        RCL_SVC_IDLE  = 1'b0,
        RCL_SVC_ARMED = 1'b1
    } rcl_svc_type;

    // Reset-cause flags as carried between logic groups
    typedef struct packed {
        logic por;
        logic pin;
        logic wdog;
        logic bad_opcode;
        logic bad_address;
        logic lowvolt;
    } rcl_cause_type;

endpackage : rcl_pkg

// ==== tb/rcl_reset_ctrl_tb_top.sv ====
/*
 * Self-checking bench of the reset-cause and low-voltage control block.
 * Assumes the design answers APB with no wait states and that the
 * watchdog count is shortened through WDOG_TIMEOUT.
 */
`timescale 1ns/10ps
module rcl_reset_ctrl_tb_top;
    localparam int TMO = 2000;
    logic        clock, srst, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r, seed;
    logic        pready, pslverr, e, pin_n, lv_low, lv_high, lv_warn;
    logic        stop_deep;
    logic [4:0]  ev_m, pin_q;
    logic        sys_reset, mon_on, stop_act, stop2_act, warn_irq, irq;
    logic [7:0]  key;
    int          n_errors, n_checks, cyc, cause_m, hi;
    int          act[$];

    rcl_reset_ctrl #(.WDOG_TIMEOUT(TMO)) DUT (
        .CLOCK(clock), .SRST(srst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .PIN_RESET_N(pin_q[4]),
        .LV_BELOW_LOW(pin_q[3]), .LV_BELOW_HIGH(pin_q[2]),
        .LV_WARN_LEVEL(pin_q[1]), .BAD_OPCODE(ev_m[0]),
        .BAD_ADDRESS(ev_m[1]), .STOP_REQ(ev_m[2]), .STOP_DEEP(pin_q[0]),
        .DEBUG_ENTER_REQ(ev_m[3]), .WAKE(ev_m[4]), .SYS_RESET(sys_reset),
        .LV_MONITOR_ON(mon_on), .STOP_ACTIVE(stop_act),
        .STOP2_ACTIVE(stop2_act), .LOWVOLT_WARN_IRQ(warn_irq), .IRQ(irq)
    );

    // 40 MHz clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // Pin levels reach the design only on a rising edge
    always @(posedge clock) begin
        pin_q <= {pin_n, lv_low, lv_high, lv_warn, stop_deep};
    end

    // Hang guard, well above the longest expected run
    always @(posedge clock) begin
        cyc <= cyc + 1;
        hi  <= sys_reset ? hi + 1 : 0;
        if (cyc == 40000) begin
            n_errors++;
            print_verdict();
        end
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00);
        chk(r, exp);
    endtask : rd

    // Sample settled outputs half a cycle after the n-th edge
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask : settle

    // Mask bits: opcode, address, stop, debug entry, wake
    task automatic ev(input logic [4:0] m);
        @(posedge clock);
        ev_m <= m;
        @(posedge clock);
        ev_m <= 5'h00;
    endtask : ev

    task automatic wait_rst(input int lim);
        int n;
        n = 0;
        while (sys_reset !== 1'b1 && n < lim) begin
            @(negedge clock);
            n++;
        end
        chk({31'h0, sys_reset}, 32'h1);
    endtask : wait_rst

    // Hold length must reach the four-cycle minimum and end
    task automatic wait_run();
        int n;
        n = 0;
        while (sys_reset !== 1'b0 && n < 300) begin
            @(negedge clock);
            n++;
        end
        chk({31'h0, hi >= 4 && n < 300}, 32'h1);
    endtask : wait_run

    // Cause model: sources queued 0 por,1 pin,2 wdog,3 op,4 ad,5 lv,6 dbg
    task automatic model_reset(input logic [31:0] seen);
        int c;
        int lv;
        c = 0;
        lv = 0;
        foreach (act[i]) begin
            if (act[i] == 5) lv = 1;
            else if (act[i] == 0) c = 'h82;
            else if (act[i] != 6) c |= 1 << (7 - act[i]);
        end
        if (lv) c = (cause_m & 'h80) | 'h02;
        cause_m = c;
        act.delete();
        rd(rcl_pkg::ADDR_CAUSE, cause_m);
    endtask : model_reset

    task automatic src_rst(input logic [4:0] m, input int s);
        ev(m);
        act.push_back(s);
        if (m == 5'h03) act.push_back(4);
        wait_rst(6);
        wait_run();
        model_reset(r);
    endtask : src_rst

    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {ev_m, stop_deep} = '0;
        {pin_n, lv_low, lv_high, lv_warn, srst} = 5'b11101;
        seed = 32'h00000045;
        n_errors = 0;
        n_checks = 0;
        cyc = 0;
        cause_m = 0;
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        settle(20);
        chk({31'h0, sys_reset}, 32'h1);
        lv_low  <= 1'b0;
        lv_high <= 1'b0;
        wait_run();
        act.push_back(0);
        model_reset(r);
        rd(rcl_pkg::ADDR_PMC1, rcl_pkg::PMC1_RESET);
        rd(rcl_pkg::ADDR_SOPT, rcl_pkg::SOPT_RESET);
        rd(rcl_pkg::ADDR_PMC2, rcl_pkg::PMC2_RESET);
        rd(rcl_pkg::ADDR_IRQ_MASK, 32'h0);
        rd(8'h1C, 32'h0);
        chk({31'h0, e}, 32'h1);
        // Service keys leave the read-only flags alone
        apb(1'b1, rcl_pkg::ADDR_CAUSE, rcl_pkg::WDOG_KEY_ARM);
        apb(1'b1, rcl_pkg::ADDR_CAUSE, rcl_pkg::WDOG_KEY_DONE);
        rd(rcl_pkg::ADDR_CAUSE, cause_m);
        apb(1'b1, rcl_pkg::ADDR_IRQ_MASK, 8'h03);
        rd(rcl_pkg::ADDR_IRQ_STAT, 32'h2);
        settle(0);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, rcl_pkg::ADDR_IRQ_STAT, 8'h02);
        settle(1);
        chk({31'h0, irq}, 32'h0);
        // Low-voltage reset keeps the power-on flag
        {lv_low, lv_high} <= 2'b11;
        wait_rst(8);
        settle(20);
        chk({31'h0, sys_reset}, 32'h1);
        {lv_low, lv_high} <= 2'b00;
        wait_run();
        act.push_back(5);
        model_reset(r);
        lv_high <= 1'b1;
        settle(10);
        chk({31'h0, sys_reset}, 32'h0);
        lv_high <= 1'b0;
        apb(1'b1, rcl_pkg::ADDR_PMC2, 8'h20);
        settle(4);
        lv_high <= 1'b1;
        wait_rst(8);
        settle(10);
        chk({31'h0, sys_reset}, 32'h1);
        lv_high <= 1'b0;
        wait_run();
        act.push_back(5);
        model_reset(r);
        apb(1'b1, rcl_pkg::ADDR_PMC1, 8'h00);
        {lv_low, lv_high} <= 2'b11;
        settle(8);
        chk({30'h0, mon_on, sys_reset}, 32'h0);
        {lv_low, lv_high} <= 2'b00;
        // Warning flag and its interrupt
        apb(1'b1, rcl_pkg::ADDR_PMC1, 8'h24);
        settle(0);
        chk({31'h0, mon_on}, 32'h1);
        apb(1'b1, rcl_pkg::ADDR_IRQ_MASK, 8'h01);
        lv_warn <= 1'b1;
        settle(5);
        lv_warn <= 1'b0;
        chk({30'h0, warn_irq, irq}, 32'h3);
        rd(rcl_pkg::ADDR_PMC1, 32'hA4);
        apb(1'b1, rcl_pkg::ADDR_PMC1, 8'h64);
        apb(1'b1, rcl_pkg::ADDR_IRQ_STAT, 8'h01);
        settle(1);
        chk({30'h0, warn_irq, irq}, 32'h0);
        // Stop entry with and without the monitor kept alive
        apb(1'b1, rcl_pkg::ADDR_SOPT, 8'h20);
        apb(1'b1, rcl_pkg::ADDR_PMC1, 8'h0C);
        stop_deep <= 1'b1;
        ev(5'h04);
        settle(0);
        chk({29'h0, stop_act, stop2_act, mon_on}, 32'h5);
        ev(5'h10);
        apb(1'b1, rcl_pkg::ADDR_PMC1, 8'h04);
        ev(5'h04);
        settle(0);
        chk({29'h0, stop_act, stop2_act, mon_on}, 32'h6);
        ev(5'h10);
        stop_deep <= 1'b0;
        // Watchdog off: no timeout, bad key ignored
        settle(TMO + 100);
        apb(1'b1, rcl_pkg::ADDR_CAUSE, 8'h12);
        settle(2);
        chk({31'h0, sys_reset}, 32'h0);
        apb(1'b1, rcl_pkg::ADDR_SOPT, 8'h00);
        src_rst(5'h04, 3);
        src_rst(5'h08, 3);
        src_rst(5'h01, 3);
        src_rst(5'h02, 4);
        src_rst(5'h03, 3);
        // Bad key after arming, then bad key alone
        do key = 8'(xs());
        while (key == 8'h55 || key == 8'hAA ||
               key == 8'h54 || key == 8'hAB);
        apb(1'b1, rcl_pkg::ADDR_CAUSE, rcl_pkg::WDOG_KEY_ARM);
        apb(1'b1, rcl_pkg::ADDR_CAUSE, key);
        act.push_back(2);
        wait_rst(6);
        wait_run();
        model_reset(r);
        apb(1'b1, rcl_pkg::ADDR_CAUSE, key ^ 8'h01);
        act.push_back(2);
        wait_rst(6);
        wait_run();
        model_reset(r);
        // Service restarts the count, then let it expire
        settle(TMO - 300);
        apb(1'b1, rcl_pkg::ADDR_CAUSE, rcl_pkg::WDOG_KEY_ARM);
        apb(1'b1, rcl_pkg::ADDR_CAUSE, rcl_pkg::WDOG_KEY_DONE);
        settle(400);
        chk({31'h0, sys_reset}, 32'h0);
        act.push_back(2);
        wait_rst(TMO);
        wait_run();
        model_reset(r);
        pin_n <= 1'b0;
        wait_rst(8);
        settle(10);
        pin_n <= 1'b1;
        act.push_back(1);
        wait_run();
        model_reset(r);
        apb(1'b1, rcl_pkg::ADDR_DBG, 8'h01);
        act.push_back(6);
        wait_rst(6);
        wait_run();
        model_reset(r);
        print_verdict();
    end
endmodule : rcl_reset_ctrl_tb_top
